/* File: logic/cfgp_top.sv */
`timescale 1ns/1ps
`include "cfgp_defines.svh"

module cfgp_top #(
    parameter int CCK_HALF = `CFGP_CCK_HALF
) (
    input  wire logic              I_SYS_CLK,      // System clock, 25 MHz
    input  wire logic              I_NRST,         // Async reset, active low
    input  wire logic              I_CRESET_N,     // Reconfiguration request pin
    input  wire logic              I_SS_N_I,       // Slave select pin level
    input  wire logic [2:0]        I_BUS_WIDTH_SEL, // Bus width select pins
    input  wire logic [1:0]        I_IMAGE_SEL,    // Image select pins
    input  wire logic              I_MULTI_IMG_EN, // External multi-image enabled
    input  wire logic              I_CSI,          // Chip select input pin
    input  wire logic              I_CCK_I,        // Config clock pin level
    input  wire logic [31:0]       I_CDL_I,        // Config data line levels
    input  wire logic              I_CONFIG_DONE_PIN_I,      // Done pin level
    input  wire logic              I_LOAD_DONE,    // Core: bitstream complete
    input  wire logic              I_ID_MISMATCH,  // Core: ID mismatch
    input  wire logic              I_CRC_FAIL,     // Core: CRC failed
    input  wire logic              I_UPDATE_FAIL,  // Core: remote update failed
    input  wire logic              I_TCK,          // Test clock
    input  wire logic              I_TMS,          // Test mode select level
    input  wire logic              I_TMS_EN,       // TMS driven externally
    input  wire logic              I_TDI,          // Test data in level
    input  wire logic              I_TDI_EN,       // TDI driven externally
    output logic                   O_CONFIG_DONE_PIN_O,      // Done pin drive value
    output logic                   O_CONFIG_DONE_PIN_OE,     // Done pin pull-down enable
    output logic                   O_CONFIG_ERROR_N, // Error status, active low
    output logic                   O_CSO,          // Chip select to next device
    output logic                   O_CCK_O,        // Config clock drive value
    output logic                   O_CCK_OE,       // Config clock enable
    output logic [31:0]            O_CDL_O,        // Config data line values
    output logic [31:0]            O_CDL_OE,       // Config data line enables
    output logic                   O_SS_N_O,       // Slave select drive value
    output logic                   O_SS_N_OE,      // Slave select enable
    output logic                   O_RESERVED_OUT, // High while configuring
    output logic                   O_USER_MODE,    // Device in user mode
    output logic                   O_USER_IO_EN,   // Dual-purpose pins free
    output cfgp_pkg::cfgp_word_t   O_CFG_WORD,     // Assembled config word
    output logic                   O_CFG_VALID,    // Word strobe, one cycle
    output logic                   O_TDO,          // Test data out value
    output logic                   O_TDO_OE        // Test data out enable
);
    import cfgp_pkg::*;

    // Synchronised pin levels
    logic        creset_s, ss_s, csi_s, cck_s, config_done_pin_s, tog_s;
    logic [4:0]  sel_s;
    logic [31:0] cdl_s;
    cfgp_cst_t   st_q, st_d;
    logic        act_q, cck_p_q, cck_q, cdl0_q, err_q, tog_p_q;
    logic [5:0]  lanes_q, bits_q, ccnt_q;
    logic [6:0]  bsum;
    logic [1:0]  img_q;
    logic [15:0] div_q;
    logic [31:0] cmd_q, word_q, word_d, mask, din;
    logic        tick, rise_i, take, err_set, jt_take;

    cfgp_sync #(.W(42)) u_sync_sys (
        .i_clk  (I_SYS_CLK),
        .i_nrst (I_NRST),
        .i_d    ({I_CRESET_N, I_SS_N_I, I_CSI, I_CCK_I, I_CONFIG_DONE_PIN_I,
                  I_BUS_WIDTH_SEL, I_IMAGE_SEL, I_CDL_I}),
        .o_q    ({creset_s, ss_s, csi_s, cck_s, config_done_pin_s, sel_s, cdl_s})
    );

    // Lane count decode from the bus-width select code
    function automatic logic [5:0] lanes_of(input logic [2:0] code);
        case (code)
            `CFGP_BUS_WIDTH_SELECT_X2:  lanes_of = 6'h02;
            `CFGP_BUS_WIDTH_SELECT_X4:  lanes_of = 6'h04;
            `CFGP_BUS_WIDTH_SELECT_X8:  lanes_of = 6'h08;
            `CFGP_BUS_WIDTH_SELECT_X16: lanes_of = 6'h10;
            `CFGP_BUS_WIDTH_SELECT_X32: lanes_of = 6'h20;
            default:        lanes_of = 6'h01;
        endcase
    endfunction : lanes_of

    // Error causes; sticky until reconfiguration
    assign err_set = I_ID_MISMATCH | I_CRC_FAIL | I_UPDATE_FAIL;

    // Sequencer next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            CST_SENSE: begin
                if (creset_s && csi_s) begin
                    st_d = ss_s ? CST_CMD : CST_LOAD;
                end
            end
            CST_CMD: begin
                if (rise_i && ccnt_q == 6'h1f) begin
                    st_d = CST_LOAD;
                end
            end
            CST_LOAD: begin
                if (err_set) begin
                    st_d = CST_ERROR;
                end else if (I_LOAD_DONE) begin
                    st_d = CST_RELEASE;
                end
            end
            CST_RELEASE: begin
                if (err_set) begin
                    st_d = CST_ERROR;
                end else if (config_done_pin_s) begin
                    st_d = CST_USER;
                end
            end
            CST_USER:  st_d = CST_USER;
            CST_ERROR: st_d = CST_ERROR;
            default:   st_d = CST_SENSE;
        endcase
        // Reconfig request restarts the loader from any state
        if (!creset_s) begin
            st_d = CST_SENSE;
        end
    end

    // Sequencer state register
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_q <= CST_SENSE;
        end else begin
            st_q <= st_d;
        end
    end

    // Mode, width and image captured when leaving the sense state
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            act_q   <= 1'b0;
            lanes_q <= 6'h01;
            img_q   <= 2'h0;
        end else if (st_q == CST_SENSE && st_d != CST_SENSE) begin
            act_q   <= ss_s;
            lanes_q <= lanes_of(sel_s[4:2]);
            img_q   <= I_MULTI_IMG_EN ? sel_s[1:0] : 2'h0;
        end
    end

    // Error flag: a new failure wins over the clear
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            err_q <= 1'b0;
        end else if (err_set) begin
            err_q <= 1'b1;
        end else if (!creset_s) begin
            err_q <= 1'b0;
        end
    end

    // Internal config clock divider for active mode
    assign tick   = (st_q == CST_CMD || st_q == CST_LOAD) && act_q &&
                    div_q == 16'(CCK_HALF - 1);
    assign rise_i = tick && !cck_q;
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            div_q <= 16'h0000;
            cck_q <= 1'b0;
        end else if (!((st_q == CST_CMD || st_q == CST_LOAD) && act_q)) begin
            div_q <= 16'h0000;
            cck_q <= 1'b0;
        end else if (tick) begin
            div_q <= 16'h0000;
            cck_q <= ~cck_q;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // Flash read command with image base, shifted out on line 0
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmd_q  <= 32'h0000_0000;
            ccnt_q <= 6'h00;
            cdl0_q <= 1'b0;
        end else if (st_q == CST_SENSE) begin
            cmd_q  <= {`CFGP_FLASH_READ,
                       24'(I_MULTI_IMG_EN ? sel_s[1:0] : 2'h0) << `CFGP_IMG_LSB};
            ccnt_q <= 6'h00;
            cdl0_q <= 1'(`CFGP_FLASH_READ >> 7);
        end else if (st_q == CST_CMD) begin
            if (rise_i) begin
                ccnt_q <= ccnt_q + 6'h01;
            end
            if (tick && cck_q) begin
                cmd_q  <= cmd_q << 1;
                cdl0_q <= cmd_q[30];
            end
        end
    end
    // Captured image index is unused; the command takes the select pins directly
    logic unused_img;
    assign unused_img = ^img_q;

    // Passive clock edge detect on the synchronised level
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cck_p_q <= 1'b0;
        end else begin
            cck_p_q <= cck_s;
        end
    end

    // Sample point: own clock in active mode, pin clock in passive
    assign take = st_q == CST_LOAD && csi_s &&
                  (act_q ? rise_i : (cck_s && !cck_p_q));
    // Lane 0 is serial in for passive, lane 1 for active
    assign din  = (lanes_q == 6'h01) ?
                  {31'h0, act_q ? cdl_s[1] : cdl_s[0]} : cdl_s;
    assign mask = (lanes_q == 6'h20) ? 32'hffff_ffff :
                  ((32'h1 << lanes_q) - 32'h1);
    assign word_d = (word_q << lanes_q) | (din & mask);
    assign bsum   = {1'b0, bits_q} + {1'b0, lanes_q};

    // Word assembly, MSB first
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            word_q <= 32'h0000_0000;
            bits_q <= 6'h00;
        end else if (st_q == CST_SENSE) begin
            bits_q <= 6'h00;
        end else if (take) begin
            word_q <= word_d;
            bits_q <= (bsum == 7'h20) ? 6'h00 : bsum[5:0];
        end
    end

    // Boundary-scan words arrive by toggle, data held stable meanwhile
    logic [31:0] jt_word;
    logic        jt_tog;
    cfgp_sync #(.W(1)) u_sync_tog (
        .i_clk  (I_SYS_CLK),
        .i_nrst (I_NRST),
        .i_d    (jt_tog),
        .o_q    (tog_s)
    );
    assign jt_take = (tog_s ^ tog_p_q) && csi_s &&
                     (st_q == CST_SENSE || st_q == CST_LOAD);

    // Word output; pin word has priority over a boundary-scan word
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tog_p_q     <= 1'b0;
            O_CFG_WORD  <= '0;
            O_CFG_VALID <= 1'b0;
        end else begin
            tog_p_q     <= tog_s;
            O_CFG_VALID <= 1'b0;
            if (take && bsum == 7'h20) begin
                O_CFG_WORD  <= '{data: word_d, from_jtag: 1'b0};
                O_CFG_VALID <= 1'b1;
            end else if (jt_take) begin
                O_CFG_WORD  <= '{data: jt_word, from_jtag: 1'b1};
                O_CFG_VALID <= 1'b1;
            end
        end
    end

    // Pin drives; dual-purpose pins released in user mode
    assign O_CONFIG_DONE_PIN_O        = 1'b0;
    assign O_CONFIG_DONE_PIN_OE       = !(st_q == CST_RELEASE || st_q == CST_USER);
    assign O_CONFIG_ERROR_N = !err_q;
    assign O_USER_MODE      = st_q == CST_USER;
    assign O_USER_IO_EN     = st_q == CST_USER;
    assign O_RESERVED_OUT   = st_q != CST_USER;
    assign O_CSO            = st_q == CST_RELEASE;
    assign O_CCK_O          = cck_q;
    assign O_CCK_OE         = act_q && (st_q == CST_CMD || st_q == CST_LOAD);
    assign O_SS_N_O         = 1'b0;
    assign O_SS_N_OE        = act_q && (st_q == CST_CMD || st_q == CST_LOAD);
    assign O_CDL_O          = {30'h0, cdl_s[0], cdl0_q};
    // Line 0 out for active command, line 1 forwards line 0 during release in passive x1
    assign O_CDL_OE = {30'h0,
                       !act_q && lanes_q == 6'h01 && st_q == CST_RELEASE,
                       act_q && st_q == CST_CMD};

    // ---- Test access port, TCK domain ----
    cfgp_tap_t        tap_q, tap_d;
    logic             tms_w, tdi_w, csi_t, byp_q, ser;
    logic [3:0]       ir_q, ir_sr;
    logic [31:0]      id_sr, cfg_sr, jt_word_q;
    logic             jt_tog_q;

    // Weak pull-ups: undriven inputs read as one
    assign tms_w = I_TMS_EN ? I_TMS : 1'b1;
    assign tdi_w = I_TDI_EN ? I_TDI : 1'b1;

    cfgp_sync #(.W(1)) u_sync_csi (
        .i_clk  (I_TCK),
        .i_nrst (I_NRST),
        .i_d    (I_CSI),
        .o_q    (csi_t)
    );

    // TAP controller next state
    always_comb begin
        tap_d = tap_q;
        case (tap_q)
            TS_TLR:    tap_d = tms_w ? TS_TLR    : TS_RTI;
            TS_RTI:    tap_d = tms_w ? TS_SEL_DR : TS_RTI;
            TS_SEL_DR: tap_d = tms_w ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_d = tms_w ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  tap_d = tms_w ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_d = tms_w ? TS_UPD_DR : TS_PA_DR;
            TS_PA_DR:  tap_d = tms_w ? TS_EX2_DR : TS_PA_DR;
            TS_EX2_DR: tap_d = tms_w ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: tap_d = tms_w ? TS_SEL_DR : TS_RTI;
            TS_SEL_IR: tap_d = tms_w ? TS_TLR    : TS_CAP_IR;
            TS_CAP_IR: tap_d = tms_w ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  tap_d = tms_w ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_d = tms_w ? TS_UPD_IR : TS_PA_IR;
            TS_PA_IR:  tap_d = tms_w ? TS_EX2_IR : TS_PA_IR;
            TS_EX2_IR: tap_d = tms_w ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: tap_d = tms_w ? TS_SEL_DR : TS_RTI;
            default:   tap_d = TS_TLR;
        endcase
    end

    // TAP state advances on rising TCK
    always_ff @(posedge I_TCK or negedge I_NRST) begin
        if (!I_NRST) begin
            tap_q <= TS_TLR;
        end else begin
            tap_q <= tap_d;
        end
    end

    // Instruction register path
    always_ff @(posedge I_TCK or negedge I_NRST) begin
        if (!I_NRST) begin
            ir_sr <= `CFGP_IR_IDCODE;
            ir_q  <= `CFGP_IR_IDCODE;
        end else begin
            case (tap_q)
                TS_TLR:    ir_q  <= `CFGP_IR_IDCODE;
                TS_CAP_IR: ir_sr <= 4'h1;
                TS_SH_IR:  ir_sr <= {tdi_w, ir_sr[3:1]};
                TS_UPD_IR: ir_q  <= ir_sr;
                default:   ir_q  <= ir_q;
            endcase
        end
    end

    // Data registers: bypass, identification, configuration word
    always_ff @(posedge I_TCK or negedge I_NRST) begin
        if (!I_NRST) begin
            byp_q  <= 1'b0;
            id_sr  <= `CFGP_IDCODE;
            cfg_sr <= 32'h0000_0000;
        end else if (tap_q == TS_CAP_DR) begin
            byp_q  <= 1'b0;
            id_sr  <= `CFGP_IDCODE;
        end else if (tap_q == TS_SH_DR) begin
            case (ir_q)
                `CFGP_IR_IDCODE: id_sr  <= {tdi_w, id_sr[31:1]};
                `CFGP_IR_CFG:    cfg_sr <= {tdi_w, cfg_sr[31:1]};
                default:         byp_q  <= tdi_w;
            endcase
        end
    end

    // Completed configuration word handed to the system clock
    always_ff @(posedge I_TCK or negedge I_NRST) begin
        if (!I_NRST) begin
            jt_word_q <= 32'h0000_0000;
            jt_tog_q  <= 1'b0;
        end else if (tap_q == TS_UPD_DR && ir_q == `CFGP_IR_CFG && csi_t) begin
            jt_word_q <= cfg_sr;
            jt_tog_q  <= ~jt_tog_q;
        end
    end
    assign jt_word = jt_word_q;
    assign jt_tog  = jt_tog_q;

    // Serial output of the selected register; length sets the delay
    always_comb begin
        if (tap_q == TS_SH_IR) begin
            ser = ir_sr[0];
        end else begin
            case (ir_q)
                `CFGP_IR_IDCODE: ser = id_sr[0];
                `CFGP_IR_CFG:    ser = cfg_sr[0];
                default:         ser = byp_q;
            endcase
        end
    end

    // TDO changes after the falling edge, enabled only while shifting
    always_ff @(negedge I_TCK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_TDO    <= 1'b0;
            O_TDO_OE <= 1'b0;
        end else begin
            O_TDO    <= ser;
            O_TDO_OE <= tap_q == TS_SH_DR || tap_q == TS_SH_IR;
        end
    end

    // ---- Checks ----
    a_user_gate: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        $rose(O_USER_MODE) |-> $past(config_done_pin_s) && $past(st_q == CST_RELEASE))
        else $error("User mode entered without done pin high");
    a_done_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        $fell(O_CONFIG_DONE_PIN_OE) |-> $past(I_LOAD_DONE) && $past(!err_set))
        else $error("Done pin released before loading completed");
    a_reconfig_restart: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        !creset_s |=> st_q == CST_SENSE && !O_USER_MODE)
        else $error("Reconfiguration request did not restart loader");
    a_error_low: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        err_set |=> !O_CONFIG_ERROR_N [*2])
        else $error("Error output not held low after failure");
    a_csi_gate: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        O_CFG_VALID |-> $past(csi_s))
        else $error("Word accepted while chip select low");
    a_user_free: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        O_USER_MODE |-> !O_CCK_OE && O_CDL_OE == 32'h0 && !O_SS_N_OE && O_USER_IO_EN)
        else $error("Dual-purpose pin driven in user mode");
    a_cck_dir: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
        O_CCK_OE |-> act_q && !O_USER_MODE && O_RESERVED_OUT)
        else $error("Config clock driven in passive mode");
    a_tms_reset: assert property (@(posedge I_TCK) disable iff (!I_NRST)
        (!I_TMS_EN) [*5] |=> tap_q == TS_TLR)
        else $error("Undriven TMS did not reach test-logic-reset");
    a_ir_update: assert property (@(posedge I_TCK) disable iff (!I_NRST)
        tap_q == TS_UPD_IR |=> ir_q == $past(ir_sr))
        else $error("Instruction not loaded at update");
    a_bypass_len: assert property (@(posedge I_TCK) disable iff (!I_NRST)
        tap_q == TS_SH_DR && ir_q == `CFGP_IR_BYPASS |=> O_TDO == $past(tdi_w))
        else $error("Bypass path not one cycle long");
    a_tdo_idle: assert property (@(posedge I_TCK) disable iff (!I_NRST)
        tap_q == TS_RTI ##1 tap_q == TS_RTI |-> !O_TDO_OE)
        else $error("TDO driven while not shifting");
endmodule : cfgp_top

/* File: logic/cfgp_defines.svh */
`ifndef CFGP_DEFINES_SVH
`define CFGP_DEFINES_SVH

// Configuration data path
`define CFGP_DATA_W       32
`define CFGP_CMD_BITS     32
`define CFGP_FLASH_READ   8'h03
`define CFGP_IMG_LSB      22
`define CFGP_CCK_HALF     4

// Bus-width select codes
`define CFGP_BUS_WIDTH_SELECT_X1      3'h7
`define CFGP_BUS_WIDTH_SELECT_X2      3'h6
`define CFGP_BUS_WIDTH_SELECT_X4      3'h5
`define CFGP_BUS_WIDTH_SELECT_X8      3'h4
`define CFGP_BUS_WIDTH_SELECT_X16     3'h3
`define CFGP_BUS_WIDTH_SELECT_X32     3'h2

// Test access port instructions
`define CFGP_IR_W         4
`define CFGP_IR_IDCODE    4'h3
`define CFGP_IR_CFG       4'h5
`define CFGP_IR_BYPASS    4'hf
// Identification value is arbitrary
`define CFGP_IDCODE       32'h0a5c_0001

`endif

/* File: logic/cfgp_pkg.sv */
package cfgp_pkg;

    // Configuration sequencer states
    typedef enum logic [5:0] {
        CST_SENSE   = 6'h01,
        CST_CMD     = 6'h02,
        CST_LOAD    = 6'h04,
        CST_RELEASE = 6'h08,
        CST_USER    = 6'h10,
        CST_ERROR   = 6'h20
    } cfgp_cst_t;

    // Test access port controller states
    typedef enum logic [15:0] {
        TS_TLR    = 16'h0001,
        TS_RTI    = 16'h0002,
        TS_SEL_DR = 16'h0004,
        TS_CAP_DR = 16'h0008,
        TS_SH_DR  = 16'h0010,
        TS_EX1_DR = 16'h0020,
        TS_PA_DR  = 16'h0040,
        TS_EX2_DR = 16'h0080,
        TS_UPD_DR = 16'h0100,
        TS_SEL_IR = 16'h0200,
        TS_CAP_IR = 16'h0400,
        TS_SH_IR  = 16'h0800,
        TS_EX1_IR = 16'h1000,
        TS_PA_IR  = 16'h2000,
        TS_EX2_IR = 16'h4000,
        TS_UPD_IR = 16'h8000
    } cfgp_tap_t;

    // Assembled configuration word
    typedef struct packed {
        logic [31:0] data;
        logic        from_jtag;
    } cfgp_word_t;

endpackage : cfgp_pkg

/* File: logic/cfgp_sync.sv */
`timescale 1ns/1ps

module cfgp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,  // Destination clock
    input  wire logic         i_nrst, // Async reset, active low
    input  wire logic [W-1:0] i_d,    // Asynchronous level
    output logic      [W-1:0] o_q     // Synchronised level
);
    logic [W-1:0] meta_q;

    // Two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : cfgp_sync

/* File: test/cfgp_host_model.sv */
`timescale 1ns/1ps
// Passive host: clocks one word out on line 0, MSB first
module cfgp_host_model (
    input  wire logic i_clk, // Pacing clock
    output logic      o_cck, // Config clock, idles high on pull-up
    output logic      o_dat  // Serial data line 0
);
    // Idle levels
    initial begin
        o_cck = 1'b1;
        o_dat = 1'b0;
    end
    // Data changes while the clock is low, three cycles per half
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            o_dat = w[i];
            o_cck = 1'b0;
            repeat (3) @(negedge i_clk);
            o_cck = 1'b1;
            repeat (3) @(negedge i_clk);
        end
        o_dat = ~w[0]; // Released line shows the inverse
    endtask : send
endmodule : cfgp_host_model

/* File: test/config_pin_interface_bench.sv */
`timescale 1ns/1ps
`include "cfgp_defines.svh"
module config_pin_interface_bench;
    import cfgp_pkg::*;
    logic clk, tck, nrst, creset_n, csi, ld, crc, hold_low, config_serial_clock, dat, valid;
    logic idm, tms, tdi, tms_en, tdi_en, tdo;
    logic config_done_pin_oe, err_n, chip_select_out, res, user, uio, ss_oe, cck_oe, tdo_oe;
    cfgp_word_t word;
    int mismatches, num_checks;
    // Done pin: open drain with pull-up, optionally held low outside
    wire config_done_pin = ~config_done_pin_oe & ~hold_low;
    cfgp_host_model i_cfgp_host_model (.i_clk(clk), .o_cck(config_serial_clock), .o_dat(dat));
    cfgp_top i_cfgp_top (.I_SYS_CLK(clk), .I_NRST(nrst), .I_CRESET_N(creset_n),
        .I_SS_N_I(1'b0), .I_BUS_WIDTH_SEL(3'h7), .I_IMAGE_SEL(2'h0), .I_MULTI_IMG_EN(1'b0),
        .I_CSI(csi), .I_CCK_I(config_serial_clock), .I_CDL_I({31'h0, dat}), .I_CONFIG_DONE_PIN_I(config_done_pin),
        .I_LOAD_DONE(ld), .I_ID_MISMATCH(idm), .I_CRC_FAIL(crc), .I_UPDATE_FAIL(1'b0),
        .I_TCK(tck), .I_TMS(tms), .I_TMS_EN(tms_en), .I_TDI(tdi), .I_TDI_EN(tdi_en),
        .O_CONFIG_DONE_PIN_O(), .O_CONFIG_DONE_PIN_OE(config_done_pin_oe), .O_CONFIG_ERROR_N(err_n), .O_CSO(chip_select_out),
        .O_CCK_O(), .O_CCK_OE(cck_oe), .O_CDL_O(), .O_CDL_OE(), .O_SS_N_O(),
        .O_SS_N_OE(ss_oe), .O_RESERVED_OUT(res), .O_USER_MODE(user), .O_USER_IO_EN(uio),
        .O_CFG_WORD(word), .O_CFG_VALID(valid), .O_TDO(tdo), .O_TDO_OE(tdo_oe));
    // Clocks, unrelated in phase
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        tck = 1'b0;
        #7;
        forever #15 tck = ~tck;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // Counts cycles until a word strobe, up to a bound
    task automatic wait_valid(output int n);
        for (n = 0; n < 300 && valid !== 1'b1; n++)
            @(posedge clk) #1;
    endtask : wait_valid
    task automatic t_load(input logic [31:0] w, input logic sel);
        int n;
        @(negedge clk);
        csi = sel;
        fork
            i_cfgp_host_model.send(w);
            wait_valid(n);
        join
        chk(n < 300, sel);
        if (sel)
            chk(word.data, w);
    endtask : t_load
    task automatic t_done();
        @(negedge clk);
        hold_low = 1'b1;
        ld = 1'b1;
        @(negedge clk) ld = 1'b0;
        repeat (10) @(negedge clk);
        chk({chip_select_out, config_done_pin_oe, user, res}, 4'b1001);
        hold_low = 1'b0;
        repeat (5) @(negedge clk);
        chk({user, uio, res, chip_select_out}, 4'b1100);
    endtask : t_done
    task automatic t_reload();
        creset_n = 1'b0;
        repeat (4) @(negedge clk);
        creset_n = 1'b1;
        chk({user, config_done_pin_oe, err_n}, 3'b011);
        repeat (10) @(negedge clk);
        crc = 1'b1;
        @(negedge clk) crc = 1'b0;
        repeat (4) @(negedge clk);
        chk({err_n, user}, 2'b00);
        // Reload clears the error; an identification mismatch sets it again
        creset_n = 1'b0;
        repeat (4) @(negedge clk);
        creset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(err_n, 1'b1);
        idm = 1'b1;
        @(negedge clk) idm = 1'b0;
        repeat (4) @(negedge clk);
        chk(err_n, 1'b0);
    endtask : t_reload
    // One TCK cycle: inputs change on the falling edge, TDO read after the rise
    task automatic jstep(input logic m, input logic d);
        @(negedge tck);
        tms = m;
        tdi = d;
        @(posedge tck) #1;
    endtask : jstep
    // Identification shift, instruction load of bypass, then bypass shift
    task automatic t_jtag();
        logic [31:0] got;
        @(negedge tck);
        {tms_en, tdi_en} = 2'b11;
        for (int i = 0; i < 4; i++) jstep(i == 1, 1'b1);
        for (int i = 0; i < 32; i++) begin
            jstep(i == 31, 1'b0);
            got[i] = tdo;
        end
        chk(got, `CFGP_IDCODE);
        chk(tdo_oe, 1'b1);
        for (int i = 0; i < 5; i++) jstep(i < 3, 1'b1);
        for (int i = 0; i < 4; i++) begin
            jstep(i == 3, 1'b1);
            got[i] = tdo;
        end
        chk(got[3:0], 4'h1);
        for (int i = 0; i < 4; i++) jstep(i < 2, 1'b1);
        for (int i = 0; i < 4; i++) begin
            jstep(1'b0, i[0]);
            if (i > 0) chk(tdo, !i[0]);
        end
        @(negedge tck);
        {tms_en, tdi_en} = 2'b00;
        repeat (6) @(posedge tck);
        #1;
    endtask : t_jtag
    initial begin
        #2400000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {nrst, creset_n, csi, ld, crc, hold_low, idm, tms, tdi, tms_en, tdi_en} = 11'h20c;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        chk({config_done_pin_oe, err_n, res, user, ss_oe, cck_oe}, 6'b111000);
        t_load(32'hc3a5_0f96, 1'b1);
        t_load(32'h5a0f_3c69, 1'b0);
        t_done();
        t_reload();
        t_jtag();
        chk(tdo_oe, 1'b0);
        end_of_test();
    end
endmodule : config_pin_interface_bench
